// >>> rtl/dva_params.svh
// Purpose: Register offsets, field positions, reset values and timing constants of the volume block
// Assumes: Included by bare name from the package and the design modules
// Notes:   Definitions only
`ifndef DVA_PARAMS_SVH
`define DVA_PARAMS_SVH

`define DVA_ADDR_W              4
`define DVA_OFF_LEFT_LOW        4'h0
`define DVA_OFF_LEFT_HIGH       4'h1
`define DVA_OFF_RIGHT_LOW       4'h2
`define DVA_OFF_RIGHT_HIGH      4'h3
`define DVA_OFF_VOLUME_CTRL     4'h4
`define DVA_OFF_MODE_ONE        4'h7
`define DVA_OFF_MODE_TWO        4'h8

`define DVA_ATTEN_RST           5'h00
`define DVA_CTRL_RST            8'h00
`define DVA_APPLY_BIT           5
`define DVA_RAMP_BIT            0
`define DVA_CLIP_BIT            1
`define DVA_ATC_BIT             2
`define DVA_RATIO_LSB           2
`define DVA_RATIO_MSB           4
`define DVA_OSR_LSB             5
`define DVA_OSR_MSB             6
`define DVA_BYPASS_BIT          7
`define DVA_BSGAIN_BIT          6

`define DVA_RATIO_CODE_512      3'h1
`define DVA_RATIO_CODE_768      3'h2
`define DVA_RATIO_512           10'h200
`define DVA_RATIO_768           10'h300
`define DVA_RATIO_NONE          10'h000

`define DVA_CODE_MUTE           10'h3FF
`define DVA_STEPS_PER_HALF      10'h030
`define DVA_GAIN_UNITY          17'h10000
`define DVA_GAIN_FINE_STEP      34'h00000FC57
`define DVA_GAIN_CLIP_CUT       34'h00000CB59

// Ramp time per dB in microseconds at the base rate of each family
`define DVA_RAMP_US_PER_DB_48K  667
`define DVA_STEPS_PER_DB        8
`define DVA_BASE_RATE_KHZ       48
// Samples per 0.125dB step at low rate; medium doubles it and high quadruples it
`define DVA_RAMP_SAMPLES_BASE   ((`DVA_RAMP_US_PER_DB_48K * `DVA_BASE_RATE_KHZ) / (`DVA_STEPS_PER_DB * 1000))

`endif

// >>> rtl/dva_pkg.sv
// Purpose: Shared types of the volume block
// Assumes: Constants come from dva_params.svh
// Notes:   Types only
`include "dva_params.svh"
package dva_pkg;
    typedef logic [9:0]         dva_code_t;
    typedef logic signed [23:0] dva_sample_t;
    typedef logic [16:0]        dva_gain_t;
    typedef enum logic [1:0] {
        DVA_OSR_LOW,
        DVA_OSR_MID,
        DVA_OSR_HIGH,
        DVA_OSR_UNUSED
    } dva_osr_t;
endpackage

// >>> rtl/dva_gain_if.sv
// Purpose: Carrier between the control logic and the gain stage
// Assumes: One clock domain
// Notes:   Codes are those in force for the sample carried
`timescale 1ns/1ps
interface dva_gain_if;
    logic                 valid;
    dva_pkg::dva_sample_t smp_l;
    dva_pkg::dva_sample_t smp_r;
    dva_pkg::dva_code_t   code_l;
    dva_pkg::dva_code_t   code_r;
    logic                 clip_en;
    modport ctrl (output valid, output smp_l, output smp_r, output code_l, output code_r, output clip_en);
    modport stage (input valid, input smp_l, input smp_r, input code_l, input code_r, input clip_en);
endinterface

// >>> rtl/dva_gain_stage.sv
// Purpose: Applies the attenuation code and the anti-clipping cut to a stereo sample
// Assumes: Codes are stable in the cycle valid is high
// Notes:   One cycle of latency; 6dB per halving, so deep codes run slightly quiet
`timescale 1ns/1ps
`include "dva_params.svh"
module dva_gain_stage (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    dva_gain_if.stage                 g,
    output logic                      o_valid_r,
    output dva_pkg::dva_sample_t      o_smp_l_r,
    output dva_pkg::dva_sample_t      o_smp_r_r
);
    // Linear gain in Q16 for a code, with optional 2dB cut
    function automatic dva_pkg::dva_gain_t code_gain(input dva_pkg::dva_code_t code, input logic cut);
        logic [4:0]        sh;
        logic [5:0]        fr;
        dva_pkg::dva_gain_t gn;
        sh = 5'(code / `DVA_STEPS_PER_HALF);
        fr = 6'(code % `DVA_STEPS_PER_HALF);
        gn = `DVA_GAIN_UNITY;
        for (int i = 0; i < 47; i++) begin
            if (6'(i) < fr) begin
                gn = 17'((34'(gn) * `DVA_GAIN_FINE_STEP) >> 16);
            end
        end
        if (cut) begin
            gn = 17'((34'(gn) * `DVA_GAIN_CLIP_CUT) >> 16);
        end
        gn = (sh > 5'h10) ? 17'h00000 : (gn >> sh);
        if (code == `DVA_CODE_MUTE) begin
            gn = 17'h00000;
        end
        return gn;
    endfunction

    function automatic dva_pkg::dva_sample_t scale(input dva_pkg::dva_sample_t s, input dva_pkg::dva_gain_t gn);
        logic signed [41:0] prod;
        prod = 42'(s) * $signed({1'b0, gn});
        return prod[39:16];
    endfunction

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid_r <= 1'b0;
            o_smp_l_r <= 24'h000000;
            o_smp_r_r <= 24'h000000;
        end else begin
            o_valid_r <= g.valid;
            if (g.valid) begin
                o_smp_l_r <= scale(g.smp_l, code_gain(g.code_l, g.clip_en));
                o_smp_r_r <= scale(g.smp_r, code_gain(g.code_r, g.clip_en));
            end
        end
    end
endmodule

// >>> rtl/dva_volume_top.sv
// Purpose: Digital volume and attenuation control for a stereo converter path
// Assumes: Samples and register accesses come from logic on I_CLK
// Notes:   Register reads answer one cycle after the read strobe
// Overview of operation
// - Bypass ratio code 001 gives 512, 010 gives 768
// - Attenuate each channel 0.125dB steps, reset 0dB
// - Ten-bit code split low/high fives over registers
// - Code zero unity, each step 0.125dB, 3FF mutes
// - Writes go to pre-latch; no apply, no change
// - Apply bit moves all pre-latches at next sample
// - Apply bit is never stored or read back
// - Left-drives-both uses left code from next sample
// - Right settings kept while left drives both
// - Ramp off: new volume taken in one step
// - Ramp on: rate follows sample-rate family
// - Anti-clip bit adds fixed 2dB cut outside bypass
// - Bitstream gain bit: 0 low, 1 high
// - Bypass: volume only, filters skipped downstream
`timescale 1ns/1ps
`include "dva_params.svh"
module dva_volume_top (
    input  wire logic                      I_CLK,
    input  wire logic                      I_RST_N,
    input  wire logic                      I_REG_WE,
    input  wire logic                      I_REG_RE,
    input  wire logic [`DVA_ADDR_W-1:0]    I_REG_ADDR,
    input  wire logic [7:0]                I_REG_WDATA,
    output logic      [7:0]                O_REG_RDATA,
    output logic                           O_REG_RVALID,
    input  wire logic                      I_SAMPLE_VALID,
    input  wire dva_pkg::dva_sample_t      I_SAMPLE_L,
    input  wire dva_pkg::dva_sample_t      I_SAMPLE_R,
    output logic                           O_SAMPLE_VALID,
    output dva_pkg::dva_sample_t           O_SAMPLE_L,
    output dva_pkg::dva_sample_t           O_SAMPLE_R,
    output logic                           O_FILTER_BYPASS,
    output logic      [9:0]                O_CLOCK_RATIO,
    output logic                           O_BITSTREAM_HIGH_GAIN
);
    logic [4:0]          pre_ll_r, pre_lh_r, pre_rl_r, pre_rh_r;
    logic [7:0]          vol_ctrl_r, mode_one_r, mode_two_r;
    logic                apply_pend_r;
    dva_pkg::dva_code_t  act_l_r, act_r_r, cur_l_r, cur_r_r;
    logic                atc_eff_r;
    logic [4:0]          ramp_cnt_r;
    logic [7:0]          rdata_nxt;
    dva_pkg::dva_code_t  act_l_nxt, act_r_nxt, tgt_r_nxt, cur_l_nxt, cur_r_nxt;
    logic                atc_nxt, step_tick;
    logic [4:0]          ramp_len;
    dva_pkg::dva_osr_t   osr;
    logic                atten_wr, bypass, ramp_en;

    dva_gain_if gif ();

    function automatic dva_pkg::dva_code_t step_toward(input dva_pkg::dva_code_t cur, input dva_pkg::dva_code_t tgt);
        if (cur < tgt) begin
            return cur + 10'h001;
        end else if (cur > tgt) begin
            return cur - 10'h001;
        end
        return cur;
    endfunction

    assign atten_wr = I_REG_WE && (I_REG_ADDR <= `DVA_OFF_RIGHT_HIGH);
    assign bypass   = mode_one_r[`DVA_BYPASS_BIT];
    assign ramp_en  = vol_ctrl_r[`DVA_RAMP_BIT];
    assign osr      = dva_pkg::dva_osr_t'(mode_one_r[`DVA_OSR_MSB:`DVA_OSR_LSB]);

    // Pre-latch stage; the apply bit is never kept here
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pre_ll_r <= `DVA_ATTEN_RST;
            pre_lh_r <= `DVA_ATTEN_RST;
            pre_rl_r <= `DVA_ATTEN_RST;
            pre_rh_r <= `DVA_ATTEN_RST;
        end else if (atten_wr) begin
            unique case (I_REG_ADDR)
                `DVA_OFF_LEFT_LOW:   pre_ll_r <= I_REG_WDATA[4:0];
                `DVA_OFF_LEFT_HIGH:  pre_lh_r <= I_REG_WDATA[4:0];
                `DVA_OFF_RIGHT_LOW:  pre_rl_r <= I_REG_WDATA[4:0];
                `DVA_OFF_RIGHT_HIGH: pre_rh_r <= I_REG_WDATA[4:0];
                default: ;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            vol_ctrl_r <= `DVA_CTRL_RST;
            mode_one_r <= `DVA_CTRL_RST;
            mode_two_r <= `DVA_CTRL_RST;
        end else if (I_REG_WE) begin
            if (I_REG_ADDR == `DVA_OFF_VOLUME_CTRL) begin
                vol_ctrl_r <= I_REG_WDATA;
            end
            if (I_REG_ADDR == `DVA_OFF_MODE_ONE) begin
                mode_one_r <= I_REG_WDATA;
            end
            if (I_REG_ADDR == `DVA_OFF_MODE_TWO) begin
                mode_two_r <= I_REG_WDATA;
            end
        end
    end

    // A fresh apply in the sample cycle survives so that its value is not lost
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            apply_pend_r <= 1'b0;
        end else if (atten_wr && I_REG_WDATA[`DVA_APPLY_BIT]) begin
            apply_pend_r <= 1'b1;
        end else if (I_SAMPLE_VALID) begin
            apply_pend_r <= 1'b0;
        end
    end

    always_comb begin
        act_l_nxt = act_l_r;
        act_r_nxt = act_r_r;
        atc_nxt   = atc_eff_r;
        if (I_SAMPLE_VALID) begin
            atc_nxt = vol_ctrl_r[`DVA_ATC_BIT];
            if (apply_pend_r) begin
                act_l_nxt = {pre_lh_r, pre_ll_r};
                act_r_nxt = {pre_rh_r, pre_rl_r};
            end
        end
        tgt_r_nxt = atc_nxt ? act_l_nxt : act_r_nxt;
    end

    // Every family gives the same step time, so step length is a sample count
    always_comb begin
        unique case (osr)
            dva_pkg::DVA_OSR_LOW: ramp_len = 5'(`DVA_RAMP_SAMPLES_BASE);
            dva_pkg::DVA_OSR_MID: ramp_len = 5'(`DVA_RAMP_SAMPLES_BASE * 2);
            default:              ramp_len = 5'(`DVA_RAMP_SAMPLES_BASE * 4);
        endcase
        step_tick = I_SAMPLE_VALID && (ramp_cnt_r >= ramp_len - 5'h01);
    end

    always_comb begin
        cur_l_nxt = cur_l_r;
        cur_r_nxt = cur_r_r;
        if (I_SAMPLE_VALID) begin
            if (!ramp_en) begin
                cur_l_nxt = act_l_nxt;
                cur_r_nxt = tgt_r_nxt;
            end else if (step_tick) begin
                cur_l_nxt = step_toward(cur_l_r, act_l_nxt);
                cur_r_nxt = step_toward(cur_r_r, tgt_r_nxt);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            act_l_r   <= 10'h000;
            act_r_r   <= 10'h000;
            cur_l_r   <= 10'h000;
            cur_r_r   <= 10'h000;
            atc_eff_r <= 1'b0;
        end else begin
            act_l_r   <= act_l_nxt;
            act_r_r   <= act_r_nxt;
            cur_l_r   <= cur_l_nxt;
            cur_r_r   <= cur_r_nxt;
            atc_eff_r <= atc_nxt;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ramp_cnt_r <= 5'h00;
        end else if (!ramp_en || step_tick) begin
            ramp_cnt_r <= 5'h00;
        end else if (I_SAMPLE_VALID) begin
            ramp_cnt_r <= ramp_cnt_r + 5'h01;
        end
    end

    // Sample carries the codes in force after this sample's update
    assign gif.valid   = I_SAMPLE_VALID;
    assign gif.smp_l   = I_SAMPLE_L;
    assign gif.smp_r   = I_SAMPLE_R;
    assign gif.code_l  = cur_l_nxt;
    assign gif.code_r  = cur_r_nxt;
    assign gif.clip_en = vol_ctrl_r[`DVA_CLIP_BIT] && !bypass;

    dva_gain_stage u_gain (
        .i_clk     (I_CLK),
        .i_rst_n   (I_RST_N),
        .g         (gif),
        .o_valid_r (O_SAMPLE_VALID),
        .o_smp_l_r (O_SAMPLE_L),
        .o_smp_r_r (O_SAMPLE_R)
    );

    // Clock ratio and path selects; reserved codes give no ratio
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CLOCK_RATIO         <= `DVA_RATIO_NONE;
            O_FILTER_BYPASS       <= 1'b0;
            O_BITSTREAM_HIGH_GAIN <= 1'b0;
        end else begin
            O_FILTER_BYPASS       <= bypass;
            O_BITSTREAM_HIGH_GAIN <= mode_two_r[`DVA_BSGAIN_BIT];
            if (!bypass) begin
                O_CLOCK_RATIO <= `DVA_RATIO_NONE;
            end else if (mode_one_r[`DVA_RATIO_MSB:`DVA_RATIO_LSB] == `DVA_RATIO_CODE_512) begin
                O_CLOCK_RATIO <= `DVA_RATIO_512;
            end else if (mode_one_r[`DVA_RATIO_MSB:`DVA_RATIO_LSB] == `DVA_RATIO_CODE_768) begin
                O_CLOCK_RATIO <= `DVA_RATIO_768;
            end else begin
                O_CLOCK_RATIO <= `DVA_RATIO_NONE;
            end
        end
    end

    always_comb begin
        unique case (I_REG_ADDR)
            `DVA_OFF_LEFT_LOW:    rdata_nxt = {3'h0, pre_ll_r};
            `DVA_OFF_LEFT_HIGH:   rdata_nxt = {3'h0, pre_lh_r};
            `DVA_OFF_RIGHT_LOW:   rdata_nxt = {3'h0, pre_rl_r};
            `DVA_OFF_RIGHT_HIGH:  rdata_nxt = {3'h0, pre_rh_r};
            `DVA_OFF_VOLUME_CTRL: rdata_nxt = vol_ctrl_r;
            `DVA_OFF_MODE_ONE:    rdata_nxt = mode_one_r;
            `DVA_OFF_MODE_TWO:    rdata_nxt = mode_two_r;
            default:              rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_RDATA  <= 8'h00;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RE;
            if (I_REG_RE) begin
                O_REG_RDATA <= rdata_nxt;
            end
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    AST_RATIO_512: assert property (bypass && mode_one_r[4:2] == 3'h1 |=> O_CLOCK_RATIO == 10'h200)
        else $error("bypass ratio 001 not 512");
    AST_RATIO_768: assert property (bypass && mode_one_r[4:2] == 3'h2 |=> O_CLOCK_RATIO == 10'h300)
        else $error("bypass ratio 010 not 768");
    AST_NO_APPLY_HOLD: assert property (!apply_pend_r && !I_SAMPLE_VALID |=> $stable(act_l_r) && $stable(act_r_r))
        else $error("active code moved without apply");
    AST_APPLY_XFER: assert property (apply_pend_r && I_SAMPLE_VALID |=>
        act_l_r == {$past(pre_lh_r), $past(pre_ll_r)} && act_r_r == {$past(pre_rh_r), $past(pre_rl_r)})
        else $error("apply did not move the pre-latches");
    AST_APPLY_ARMS: assert property (atten_wr && I_REG_WDATA[5] |=> apply_pend_r)
        else $error("apply write not armed for next sample");
    AST_APPLY_NOT_READ: assert property (I_REG_RE && I_REG_ADDR <= 4'h3 |=> O_REG_RDATA[7:5] == 3'h0)
        else $error("apply bit read back");
    AST_ATC_RIGHT: assert property (I_SAMPLE_VALID && vol_ctrl_r[2] && !ramp_en |=> cur_r_r == cur_l_r)
        else $error("right not following left");
    AST_RIGHT_KEPT: assert property (atc_eff_r && !(I_REG_WE && (I_REG_ADDR == 4'h2 || I_REG_ADDR == 4'h3))
        |=> $stable(pre_rl_r) && $stable(pre_rh_r))
        else $error("right settings lost");
    AST_SINGLE_STEP: assert property (I_SAMPLE_VALID && !ramp_en |=> cur_l_r == act_l_r)
        else $error("volume not taken in one step");
    AST_RAMP_ONE: assert property (I_SAMPLE_VALID && ramp_en |=> (cur_l_r - $past(cur_l_r) == 10'h001)
        || ($past(cur_l_r) - cur_l_r == 10'h001) || (cur_l_r == $past(cur_l_r)))
        else $error("ramp moved more than one step");
    AST_RAMP_PACE: assert property (I_SAMPLE_VALID && ramp_en && osr == dva_pkg::DVA_OSR_LOW && ramp_cnt_r == 5'h00
        |=> $stable(cur_l_r))
        else $error("ramp stepped too early");
    AST_MUTE: assert property (I_SAMPLE_VALID && cur_l_nxt == 10'h3FF |=> O_SAMPLE_L == 24'h000000)
        else $error("code 3FF did not mute");
    AST_UNITY: assert property (I_SAMPLE_VALID && cur_l_nxt == 10'h000 && !gif.clip_en |=> O_SAMPLE_L == $past(I_SAMPLE_L))
        else $error("code zero not unity");
    AST_CLIP_CUT: assert property (I_SAMPLE_VALID && cur_l_nxt == 10'h000 && gif.clip_en && I_SAMPLE_L == 24'h100000
        |=> O_SAMPLE_L == 24'h0CB590)
        else $error("anti-clip cut wrong");
    AST_BS_GAIN: assert property (##1 O_BITSTREAM_HIGH_GAIN == $past(mode_two_r[6]))
        else $error("bitstream gain not following bit");
    // Middle family steps every eighth sample; earlier samples must hold
    AST_RAMP_MID_PACE: assert property (I_SAMPLE_VALID && ramp_en && osr == dva_pkg::DVA_OSR_MID
        && ramp_cnt_r < 5'h07 |=> $stable(cur_l_r) && $stable(cur_r_r))
        else $error("middle-rate ramp stepped too early");
    AST_BYPASS_UNITY: assert property (I_SAMPLE_VALID && bypass && cur_l_nxt == 10'h000
        |=> O_SAMPLE_L == $past(I_SAMPLE_L))
        else $error("bypass path not volume only");
    AST_BYPASS_OUT: assert property (1'b1 |=> O_FILTER_BYPASS == $past(bypass))
        else $error("bypass select not passed on");
    AST_RATIO_OFF: assert property (!bypass |=> O_CLOCK_RATIO == 10'h000)
        else $error("ratio shown outside bypass");
    AST_OUT_VALID: assert property (1'b1 |=> O_SAMPLE_VALID == $past(I_SAMPLE_VALID))
        else $error("output sample not one cycle after input");

    COV_APPLY: cover property (apply_pend_r && I_SAMPLE_VALID);
    COV_RAMP_STEP: cover property (ramp_en && step_tick && cur_l_r != act_l_nxt);
    COV_ATC: cover property (atc_eff_r && act_l_r != act_r_r);
    COV_BYPASS_768: cover property (O_FILTER_BYPASS && O_CLOCK_RATIO == 10'h300);
    COV_MUTE: cover property (I_SAMPLE_VALID && cur_l_nxt == 10'h3FF);
endmodule

// >>> dv/dva_host_model.sv
// Purpose: Audio sample source and register host facing the volume block
// Assumes: One clock; requests change by non-blocking assignment at rising edges
// Notes:   Released lines show the inverse of their last value so stale data is never mistaken for live
`timescale 1ns/1ps
`include "dva_params.svh"
module dva_host_model (
    input  wire logic                  i_clk,
    output logic                       o_we,
    output logic                       o_re,
    output logic [`DVA_ADDR_W-1:0]     o_addr,
    output logic [7:0]                 o_wdata,
    input  wire logic [7:0]            i_rdata,
    input  wire logic                  i_rvalid,
    output logic                       o_svalid,
    output dva_pkg::dva_sample_t       o_sl,
    output dva_pkg::dva_sample_t       o_sr,
    input  wire logic                  i_ovalid,
    input  wire dva_pkg::dva_sample_t  i_out_l,
    input  wire dva_pkg::dva_sample_t  i_out_r
);
    initial begin
        o_we     = 1'b0;
        o_re     = 1'b0;
        o_addr   = 4'hF;
        o_wdata  = 8'h00;
        o_svalid = 1'b0;
        o_sl     = 24'h000000;
        o_sr     = 24'h000000;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_we    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_we    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask

    // Answer is registered at the taking edge and read 1ns after it
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        o_re   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_re   <= 1'b0;
        o_addr <= ~a;
        #1;
        v = i_rvalid;
        d = i_rdata;
    endtask

    task automatic smp(input dva_pkg::dva_sample_t l, r, output dva_pkg::dva_sample_t ql, qr, output logic v);
        @(posedge i_clk);
        o_svalid <= 1'b1;
        o_sl     <= l;
        o_sr     <= r;
        @(posedge i_clk);
        o_svalid <= 1'b0;
        o_sl     <= ~l;
        o_sr     <= ~r;
        #1;
        v  = i_ovalid;
        ql = i_out_l;
        qr = i_out_r;
    endtask
endmodule

// >>> dv/dva_volume_top_test.sv
// Purpose: Self-checking bench of the volume block
// Assumes: Host model drives the register and sample inputs, the bench drives clock and reset; expectations come from the gain law
// Notes:   Ramp starts from a settled 0dB with a cleared step counter, so its pace is exact
`timescale 1ns/1ps
`include "dva_params.svh"
module dva_volume_top_test;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  we, re, rvalid, sv, ov, byp, bsg;
    logic [3:0]            addr;
    logic [7:0]            wdata, rdata;
    logic [9:0]            ratio;
    dva_pkg::dva_sample_t  sl, sr, ol, orr, gl, gr, x;
    logic [15:0]           lfsr = 16'h003A;
    int                    error_cnt = 0;
    int                    comparisons = 0;

    always #50 clk = ~clk;

    dva_volume_top u_dva_volume_top (.I_CLK(clk), .I_RST_N(rst_n), .I_REG_WE(we), .I_REG_RE(re),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_SAMPLE_VALID(sv), .I_SAMPLE_L(sl), .I_SAMPLE_R(sr), .O_SAMPLE_VALID(ov), .O_SAMPLE_L(ol),
        .O_SAMPLE_R(orr), .O_FILTER_BYPASS(byp), .O_CLOCK_RATIO(ratio), .O_BITSTREAM_HIGH_GAIN(bsg));

    dva_host_model u_dva_host_model (.i_clk(clk), .o_we(we), .o_re(re), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata), .i_rvalid(rvalid), .o_svalid(sv), .o_sl(sl), .o_sr(sr), .i_ovalid(ov),
        .i_out_l(ol), .i_out_r(orr));

    function automatic logic [15:0] lfsr_f(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic dva_pkg::dva_sample_t exp_f(input dva_pkg::dva_sample_t v, input logic [9:0] c,
                                                   input logic clip);
        logic [33:0]        g;
        logic signed [47:0] p;
        g = 34'h10000;
        for (int i = 0; i < c % `DVA_STEPS_PER_HALF; i++)
            g = (g * `DVA_GAIN_FINE_STEP) >> 5'h10;
        if (clip)
            g = (g * `DVA_GAIN_CLIP_CUT) >> 5'h10;
        g = (c == `DVA_CODE_MUTE || c / `DVA_STEPS_PER_HALF > 10'h010) ? 34'h0 : g >> (c / `DVA_STEPS_PER_HALF);
        p = v;
        p = (p * $signed({14'h0, g})) >>> 5'h10;
        return p[23:0];
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_reg(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_smp(input string n, input dva_pkg::dva_sample_t e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_ctl(input string n, input logic [9:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        u_dva_host_model.rd(a, d, v);
        chk_ctl("read_valid", 10'h001, {9'h0, v});
        chk_reg("read_data", e, d);
    endtask

    task automatic snd(input dva_pkg::dva_sample_t l, r);
        logic v;
        u_dva_host_model.smp(l, r, gl, gr, v);
        chk_ctl("out_valid", 10'h001, {9'h0, v});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_dva_host_model.wr(a, d);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        static logic [3:0] regs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h5};
        logic [9:0] c;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_ctl("ratio", 10'h000, ratio);
        foreach (regs[i])
            rreg(regs[i], 8'h00);
        x = 24'h123456;
        snd(x, x);
        chk_smp("left", x, gl);
        $display("test reset finished");
        wr(4'h0, 8'h25);
        rreg(4'h0, 8'h05);
        snd(x, x);
        chk_smp("left", exp_f(x, 10'h005, 1'b0), gl);
        wr(4'h1, 8'h02);
        wr(4'h2, 8'h03);
        snd(x, x);
        chk_smp("left", exp_f(x, 10'h005, 1'b0), gl);
        chk_smp("right", x, gr);
        wr(4'h3, 8'h21);
        rreg(4'h3, 8'h01);
        snd(x, x);
        chk_smp("left", exp_f(x, 10'h045, 1'b0), gl);
        chk_smp("right", exp_f(x, 10'h023, 1'b0), gr);
        wr(4'h0, 8'h1F);
        wr(4'h1, 8'h3F);
        snd(x, x);
        chk_smp("left", 24'h000000, gl);
        $display("test latch finished");
        wr(4'h4, 8'h04);
        snd(x, x);
        chk_smp("right", 24'h000000, gr);
        wr(4'h4, 8'h00);
        snd(x, x);
        chk_smp("right", exp_f(x, 10'h023, 1'b0), gr);
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h20);
        wr(4'h4, 8'h02);
        snd(24'h100000, x);
        chk_smp("left", 24'h0CB590, gl);
        chk_smp("right", exp_f(x, 10'h023, 1'b1), gr);
        wr(4'h4, 8'h00);
        snd(x, x);
        chk_smp("left", x, gl);
        $display("test mode finished");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_f(lfsr);
            c = (i == 0) ? 10'h3FE : lfsr[9:0];
            wr(4'h0, {3'h0, c[4:0]});
            wr(4'h1, {3'h1, c[9:5]});
            lfsr = lfsr_f(lfsr);
            x = {lfsr, lfsr[7:0]};
            snd(x, x);
            chk_smp("left", exp_f(x, c, 1'b0), gl);
            chk_smp("right", exp_f(x, 10'h023, 1'b0), gr);
        end
        $display("test random finished");
        x = 24'h400000;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h20);
        snd(x, x);
        chk_smp("left", x, gl);
        wr(4'h7, 8'h20);
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h22);
        snd(x, x);
        chk_smp("ramp_first", x, gl);
        repeat (6) snd(x, x);
        chk_smp("ramp_pace", x, gl);
        repeat (30) snd(x, x);
        chk_smp("ramp_end", exp_f(x, 10'h002, 1'b0), gl);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h20);
        $display("test ramp finished");
        for (int k = 1; k < 3; k++) begin
            wr(4'h7, {1'b1, 2'h0, k[2:0], 2'h0});
            settle();
            chk_ctl("ratio", (k == 1) ? `DVA_RATIO_512 : `DVA_RATIO_768, ratio);
            chk_ctl("bypass", 10'h001, {9'h0, byp});
        end
        rreg(4'h7, 8'h88);
        wr(4'h4, 8'h02);
        snd(24'h100000, x);
        chk_smp("left", 24'h100000, gl);
        wr(4'h4, 8'h00);
        wr(4'h7, 8'h04);
        settle();
        chk_ctl("ratio", `DVA_RATIO_NONE, ratio);
        chk_ctl("bypass", 10'h000, {9'h0, byp});
        wr(4'h8, 8'h40);
        settle();
        chk_ctl("bs_gain", 10'h001, {9'h0, bsg});
        rreg(4'h8, 8'h40);
        wr(4'h8, 8'h00);
        settle();
        chk_ctl("bs_gain", 10'h000, {9'h0, bsg});
        $display("test bypass finished");
        end_of_test();
    end
endmodule
